// ### verilog/ilt_core.sv
// ilt_core: instruction length and execution cycle sequencer
// assumes: program memory answers code_req with code_rdata same cycle;
// all inputs come from logic on sys_clk
//
// Function
// [RULE_01] mov a,rn: one byte, one cycle
// [RULE_02] mov a,direct: two bytes, two cycles
// [RULE_03] mov rn,direct: two bytes, four cycles
// [RULE_04] mov direct,direct: three bytes, four cycles
// [RULE_05] load data pointer: three bytes, three cycles
// [RULE_06] both code lookups: one byte, four cycles
// [RULE_07] on-chip aux ram moves: one byte, three
// [RULE_08] external aux ram: 3+stretch+2*setup/hold cycles
// [RULE_09] push four cycles, pop three, two bytes
// [RULE_10] exchange: register three, others four cycles
// [RULE_11] add/addc/subb: two or three cycles
// [RULE_12] inc/dec two/three/four; inc dptr one
// [RULE_13] logic ops two/three; direct writes four
// [RULE_14] clear, rotates, swap one; complement two
// [RULE_15] carry ops one, three or four cycles
// [RULE_16] carry branch 3, bit branch 4, jbc 5
// [RULE_17] calls six cycles; returns four cycles
// [RULE_18] short jumps three cycles; long jump four
// [RULE_19] compare-branch three bytes, five or four
// [RULE_20] decrement-branch: register 2/4, direct 3/5
// [RULE_21] immediate to indirect: two bytes, three
// [RULE_22] standard opcode encodings and results
`timescale 1ns/1ps
module ilt_core (
	input  wire logic                        sys_clk,
	input  wire logic                        arst_n,
	input  wire logic                        op_valid,
	input  wire logic [7:0]                  op_byte,
	output logic                             op_ready,
	input  wire logic                        ext_mem_access_sel,
	input  wire logic                        ext_ram_hit,
	input  wire logic [ilt_pkg::STR_W-1:0]   rw_strobe_stretch,
	input  wire logic [ilt_pkg::HOLD_W-1:0]  rw_setup_hold_ext,
	output logic                             code_req,
	input  wire logic [7:0]                  code_rdata,
	output logic [7:0]                       opcode,
	output logic [7:0]                       opnd1,
	output logic [7:0]                       opnd2,
	output ilt_pkg::ilt_len_t                instr_len,
	output ilt_pkg::ilt_cyc_t                instr_cycles,
	output logic                             instr_ext,
	output logic                             busy,
	output logic                             instr_done
);
	//------------------------------------------------
	// declarations
	//------------------------------------------------
	ilt_pkg::ilt_state_e state;   // sequencer state
	ilt_pkg::ilt_cyc_t   remain;  // cycles left after this one
	ilt_pkg::ilt_len_t   bidx;    // next operand byte index
	logic                accept;  // opcode taken this cycle
	logic                exec;    // executing
	ilt_pkg::ilt_cyc_t   exp_ext; // expected external length

	ilt_dec_if dec_if ();        // decoder link

	//------------------------------------------------
	// decoder
	//------------------------------------------------
	// settings are sampled with the opcode
	assign dec_if.opcode  = op_byte;
	assign dec_if.ext_sel = ext_mem_access_sel;
	assign dec_if.ext_hit = ext_ram_hit;
	assign dec_if.stretch = rw_strobe_stretch;
	assign dec_if.setup_hold = rw_setup_hold_ext;

	ilt_decoder ilt_decoder_i (
		.dif (dec_if.dec)
	);

	//------------------------------------------------
	// handshake
	//------------------------------------------------
	// last cycle of an instruction frees the core
	assign exec       = (state == ilt_pkg::ST_EXEC);
	assign instr_done = exec & (remain == ilt_pkg::C0);
	// a new opcode may overlap the last cycle
	assign op_ready   = (state == ilt_pkg::ST_IDLE) | instr_done;
	assign accept     = op_valid & op_ready;
	assign busy       = exec;
	// operand bytes fetched while any remain
	assign code_req   = exec & (bidx < instr_len);

	//------------------------------------------------
	// state
	//------------------------------------------------
	// idle until an opcode, back to idle when done unless the next one is taken
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= ilt_pkg::ST_IDLE;
		end else begin
			case (state)
				ilt_pkg::ST_IDLE: begin
					if (accept) begin
						state <= ilt_pkg::ST_EXEC;
					end
				end
				ilt_pkg::ST_EXEC: begin
					// stays busy when the next one is taken
					if (instr_done && !accept) begin
						state <= ilt_pkg::ST_IDLE;
					end
				end
				default: state <= ilt_pkg::ST_IDLE;
			endcase
		end
	end

	//------------------------------------------------
	// cycle counter
	//------------------------------------------------
	// counts the decoded cycles down to zero
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			remain <= ilt_pkg::C0;
		end else if (accept) begin
			// first cycle is the one after accept
			remain <= dec_if.cyc - ilt_pkg::C1; // RULE_08
		end else if (exec && remain != ilt_pkg::C0) begin
			remain <= remain - ilt_pkg::C1;
		end
	end

	//------------------------------------------------
	// instruction record
	//------------------------------------------------
	// length, cycles and opcode held for the whole instruction
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			opcode       <= 8'h00;
			instr_len    <= ilt_pkg::L1;
			instr_cycles <= ilt_pkg::C1;
			instr_ext    <= 1'b0;
		end else if (accept) begin
			opcode       <= op_byte;
			instr_len    <= dec_if.len;
			instr_cycles <= dec_if.cyc;
			instr_ext    <= dec_if.is_ext;
		end
	end

	//------------------------------------------------
	// operand fetch
	//------------------------------------------------
	// byte index restarts at one with each opcode
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			bidx <= ilt_pkg::L1;
		end else if (accept) begin
			bidx <= ilt_pkg::L1;
		end else if (code_req) begin
			bidx <= bidx + ilt_pkg::L1;
		end
	end

	// operand bytes in fetch order
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			opnd1 <= 8'h00;
			opnd2 <= 8'h00;
		end else if (code_req) begin
			if (bidx == ilt_pkg::L1) begin
				opnd1 <= code_rdata;
			end else begin
				opnd2 <= code_rdata;
			end
		end
	end

	//------------------------------------------------
	// checks
	//------------------------------------------------
	// expected external length, for the checks only
	assign exp_ext = ilt_pkg::X_BASE
		+ ilt_pkg::ilt_cyc_t'(rw_strobe_stretch)
		+ ilt_pkg::ilt_cyc_t'({rw_setup_hold_ext, 1'b0});

	// register move finishes in the next cycle
	a_mov_a_rn: assert property ( // RULE_01
		@(posedge sys_clk) disable iff (!arst_n)
		accept && op_byte[7:3] == ilt_pkg::OP_MOV_A_RN
		|=> instr_done && instr_len == ilt_pkg::L1)
		else $error("mov a,rn not one byte one cycle");

	// direct load: two bytes, done on second cycle
	a_mov_a_dir: assert property ( // RULE_02
		@(posedge sys_clk) disable iff (!arst_n)
		accept && op_byte == ilt_pkg::OP_MOV_A_D
		|=> code_req && !instr_done ##1 instr_done
		&& instr_len == ilt_pkg::L2)
		else $error("mov a,direct timing wrong");

	// direct to register: four cycles
	a_mov_rn_dir: assert property ( // RULE_03
		@(posedge sys_clk) disable iff (!arst_n)
		accept && op_byte[7:3] == ilt_pkg::OP_MOV_RN_D
		|=> !instr_done [*3] ##1 instr_done
		&& instr_len == ilt_pkg::L2)
		else $error("mov rn,direct timing wrong");

	// direct to direct: three bytes, four cycles
	a_mov_dd: assert property ( // RULE_04
		@(posedge sys_clk) disable iff (!arst_n)
		accept && op_byte == ilt_pkg::OP_MOV_DD
		|=> code_req [*2] ##1 !code_req ##1 instr_done
		&& instr_len == ilt_pkg::L3)
		else $error("mov direct,direct timing wrong");

	// pointer load: three bytes, three cycles
	a_mov_dptr: assert property ( // RULE_05
		@(posedge sys_clk) disable iff (!arst_n)
		accept && op_byte == ilt_pkg::OP_MOV_DPTR
		|=> code_req [*2] ##1 instr_done && !code_req)
		else $error("dptr load timing wrong");

	// code lookups: one byte, four cycles
	a_movc: assert property ( // RULE_06
		@(posedge sys_clk) disable iff (!arst_n)
		accept && (op_byte == ilt_pkg::OP_MOVC_PC
		|| op_byte == ilt_pkg::OP_MOVC_DP)
		|=> !code_req && !instr_done [*3] ##1 instr_done)
		else $error("code lookup timing wrong");

	// on-chip aux ram: three cycles
	a_movx_int: assert property ( // RULE_07
		@(posedge sys_clk) disable iff (!arst_n)
		accept && dec_if.is_movx && !dec_if.is_ext
		|=> instr_cycles == ilt_pkg::C3 && instr_len == ilt_pkg::L1)
		else $error("on-chip aux ram move not three cycles");

	// external aux ram follows the stretch settings
	a_movx_ext: assert property ( // RULE_08
		@(posedge sys_clk) disable iff (!arst_n)
		accept && dec_if.is_movx && ext_mem_access_sel
		&& ext_ram_hit
		|=> instr_ext && instr_cycles == $past(exp_ext))
		else $error("external aux ram length wrong");

	// select off: aux ram moves keep the on-chip length
	a_movx_sel_off: assert property ( // RULE_08
		@(posedge sys_clk) disable iff (!arst_n)
		accept && dec_if.is_movx && !ext_mem_access_sel
		|=> !instr_ext && instr_cycles == ilt_pkg::C3)
		else $error("aux ram move stretched with select off");

	// push four cycles, pop three
	a_push_pop: assert property ( // RULE_09
		@(posedge sys_clk) disable iff (!arst_n)
		accept && (op_byte == ilt_pkg::OP_PUSH
		|| op_byte == ilt_pkg::OP_POP)
		|=> instr_len == ilt_pkg::L2 && instr_cycles
		== ((opcode == ilt_pkg::OP_PUSH) ? ilt_pkg::C4
		: ilt_pkg::C3))
		else $error("push or pop timing wrong");

	// exchange with a direct byte
	a_xch_dir: assert property ( // RULE_10
		@(posedge sys_clk) disable iff (!arst_n)
		accept && op_byte == ilt_pkg::OP_XCH_D
		|=> !instr_done [*3] ##1 instr_done)
		else $error("xch direct timing wrong");

	// add from direct byte: three cycles
	a_add_dir: assert property ( // RULE_11
		@(posedge sys_clk) disable iff (!arst_n)
		accept && op_byte == ilt_pkg::OP_ADD_D
		|=> !instr_done [*2] ##1 instr_done)
		else $error("add direct timing wrong");

	// pointer increment: one cycle
	a_inc_dptr: assert property ( // RULE_12
		@(posedge sys_clk) disable iff (!arst_n)
		accept && op_byte == ilt_pkg::OP_INC_DPTR
		|=> instr_done && !code_req)
		else $error("inc dptr not one cycle");

	// logic op into direct byte: four cycles
	a_anl_dir: assert property ( // RULE_13
		@(posedge sys_clk) disable iff (!arst_n)
		accept && op_byte == ilt_pkg::OP_ANL_DI
		|=> instr_len == ilt_pkg::L3 ##3 instr_done)
		else $error("anl direct,#data timing wrong");

	// accumulator complement: two cycles
	a_cpl_a: assert property ( // RULE_14
		@(posedge sys_clk) disable iff (!arst_n)
		accept && op_byte == ilt_pkg::OP_CPL_A
		|=> !instr_done ##1 instr_done)
		else $error("cpl a timing wrong");

	// carry to bit: four cycles
	a_mov_bit_c: assert property ( // RULE_15
		@(posedge sys_clk) disable iff (!arst_n)
		accept && op_byte == ilt_pkg::OP_MOV_BC
		|=> instr_cycles == ilt_pkg::C4 ##3 instr_done)
		else $error("mov bit,c timing wrong");

	// bit test and clear branch: five cycles
	a_jbc: assert property ( // RULE_16
		@(posedge sys_clk) disable iff (!arst_n)
		accept && op_byte == ilt_pkg::OP_JBC
		|=> !instr_done [*4] ##1 instr_done)
		else $error("jbc timing wrong");

	// long call: six cycles
	a_lcall: assert property ( // RULE_17
		@(posedge sys_clk) disable iff (!arst_n)
		accept && op_byte == ilt_pkg::OP_LCALL
		|=> !instr_done [*5] ##1 instr_done)
		else $error("lcall timing wrong");

	// long jump: three bytes, four cycles
	a_ljmp: assert property ( // RULE_18
		@(posedge sys_clk) disable iff (!arst_n)
		accept && op_byte == ilt_pkg::OP_LJMP
		|=> instr_len == ilt_pkg::L3 ##3 instr_done)
		else $error("ljmp timing wrong");

	// compare against direct: five cycles
	a_cjne_dir: assert property ( // RULE_19
		@(posedge sys_clk) disable iff (!arst_n)
		accept && op_byte == ilt_pkg::OP_CJNE_AD
		|=> instr_len == ilt_pkg::L3 ##4 instr_done)
		else $error("cjne a,direct timing wrong");

	// decrement direct and branch: five cycles
	a_djnz_dir: assert property ( // RULE_20
		@(posedge sys_clk) disable iff (!arst_n)
		accept && op_byte == ilt_pkg::OP_DJNZ_D
		|=> instr_cycles == ilt_pkg::C5 ##4 instr_done)
		else $error("djnz direct timing wrong");

	// immediate to indirect: two bytes, three cycles
	a_mov_ri_imm: assert property ( // RULE_21
		@(posedge sys_clk) disable iff (!arst_n)
		accept && op_byte[7:1] == ilt_pkg::OP_MOV_RI_I
		|=> code_req ##2 instr_done && instr_len == ilt_pkg::L2)
		else $error("mov @ri,#data timing wrong");

	// every operand byte fetched by the last cycle
	a_fetch_done: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		instr_done |-> !code_req && bidx == instr_len)
		else $error("operand bytes still pending at done");
endmodule : ilt_core

// ### verilog/ilt_pkg.sv
// ilt_pkg: widths, byte and cycle counts, opcodes and states
// assumes: compiled first; used by the decoder and the timing core
package ilt_pkg;
	// field widths
	localparam int LEN_W  = 2;
	localparam int CYC_W  = 4;
	localparam int STR_W  = 2;
	localparam int HOLD_W = 2;
	typedef logic [LEN_W-1:0] ilt_len_t;
	typedef logic [CYC_W-1:0] ilt_cyc_t;
	typedef logic [7:0]       ilt_op_t;
	// instruction byte counts
	localparam ilt_len_t L1 = 2'h1;
	localparam ilt_len_t L2 = 2'h2;
	localparam ilt_len_t L3 = 2'h3;
	// execution cycle counts
	localparam ilt_cyc_t C0 = 4'h0;
	localparam ilt_cyc_t C1 = 4'h1;
	localparam ilt_cyc_t C2 = 4'h2;
	localparam ilt_cyc_t C3 = 4'h3;
	localparam ilt_cyc_t C4 = 4'h4;
	localparam ilt_cyc_t C5 = 4'h5;
	localparam ilt_cyc_t C6 = 4'h6;
	// base of an external aux ram access
	localparam ilt_cyc_t X_BASE = 4'h3;
	// opcodes that the core checks itself
	localparam logic [4:0] OP_MOV_A_RN  = 5'h1d;
	localparam logic [4:0] OP_MOV_RN_D  = 5'h15;
	localparam ilt_op_t    OP_MOV_A_D   = 8'he5;
	localparam ilt_op_t    OP_MOV_DD    = 8'h85;
	localparam ilt_op_t    OP_MOV_DPTR  = 8'h90;
	localparam ilt_op_t    OP_MOVC_PC   = 8'h83;
	localparam ilt_op_t    OP_MOVC_DP   = 8'h93;
	localparam ilt_op_t    OP_PUSH      = 8'hc0;
	localparam ilt_op_t    OP_POP       = 8'hd0;
	localparam ilt_op_t    OP_XCH_D     = 8'hc5;
	localparam ilt_op_t    OP_ADD_D     = 8'h25;
	localparam ilt_op_t    OP_INC_DPTR  = 8'ha3;
	localparam ilt_op_t    OP_ANL_DI    = 8'h53;
	localparam ilt_op_t    OP_CPL_A     = 8'hf4;
	localparam ilt_op_t    OP_MOV_BC    = 8'h92;
	localparam ilt_op_t    OP_JBC       = 8'h10;
	localparam ilt_op_t    OP_LCALL     = 8'h12;
	localparam ilt_op_t    OP_LJMP      = 8'h02;
	localparam ilt_op_t    OP_CJNE_AD   = 8'hb5;
	localparam ilt_op_t    OP_DJNZ_D    = 8'hd5;
	localparam logic [6:0] OP_MOV_RI_I  = 7'h3b;
	// core sequencer states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_EXEC = 2'b10
	} ilt_state_e;
endpackage : ilt_pkg

// ### verilog/ilt_dec_if.sv
// ilt_dec_if: opcode and access settings in, length and cycles out
// assumes: one decoder and one timing core share an instance
`timescale 1ns/1ps
interface ilt_dec_if;
	logic [7:0]                opcode;   // first code byte
	logic                      ext_sel;  // external access select
	logic                      ext_hit;  // access maps outside
	logic [ilt_pkg::STR_W-1:0] stretch;  // strobe stretch count
	logic [ilt_pkg::HOLD_W-1:0] setup_hold; // setup/hold extension
	ilt_pkg::ilt_len_t         len;      // byte count
	ilt_pkg::ilt_cyc_t         cyc;      // cycle count
	logic                      is_movx;  // aux ram move
	logic                      is_ext;   // external aux ram move
	modport dec (input opcode, ext_sel, ext_hit, stretch, setup_hold,
		output len, cyc, is_movx, is_ext);
	modport core (output opcode, ext_sel, ext_hit, stretch, setup_hold,
		input len, cyc, is_movx, is_ext);
endinterface : ilt_dec_if

// ### verilog/ilt_decoder.sv
// ilt_decoder: opcode to byte count and execution cycle count
// assumes: pure combinational; inputs stable in the accept cycle
`timescale 1ns/1ps
module ilt_decoder (
	ilt_dec_if.dec dif
);
	//------------------------------------------------
	// lookup
	//------------------------------------------------
	// standard opcode map, first match wins
	always_comb begin // RULE_22
		dif.len = ilt_pkg::L1;
		dif.cyc = ilt_pkg::C1;
		dif.is_movx = 1'b0;
		casez (dif.opcode)
			// absolute jump / call
			8'b???00001: begin dif.len = ilt_pkg::L2; dif.cyc = ilt_pkg::C3; end // RULE_18
			8'b???10001: begin dif.len = ilt_pkg::L2; dif.cyc = ilt_pkg::C6; end // RULE_17
			8'h02: begin dif.len = ilt_pkg::L3; dif.cyc = ilt_pkg::C4; end // RULE_18
			8'h12: begin dif.len = ilt_pkg::L3; dif.cyc = ilt_pkg::C6; end // RULE_17
			8'h22, 8'h32: dif.cyc = ilt_pkg::C4; // RULE_17
			8'h10: begin dif.len = ilt_pkg::L3; dif.cyc = ilt_pkg::C5; end // RULE_16
			8'h20, 8'h30: begin dif.len = ilt_pkg::L3; dif.cyc = ilt_pkg::C4; end // RULE_16
			// inc / dec
			8'h04, 8'h14: dif.cyc = ilt_pkg::C2; // RULE_12
			8'h05, 8'h15: begin dif.len = ilt_pkg::L2; dif.cyc = ilt_pkg::C4; end // RULE_12
			8'b000?011?: dif.cyc = ilt_pkg::C4; // RULE_12
			8'b000?1???: dif.cyc = ilt_pkg::C3; // RULE_12
			// conditional and short branches, bit to carry
			8'h40, 8'h50, 8'h60, 8'h70, 8'h80, 8'h72, 8'h82, 8'ha0,
			8'ha2, 8'hb0: begin dif.len = ilt_pkg::L2; dif.cyc = ilt_pkg::C3; end // RULE_15
			8'h73: dif.cyc = ilt_pkg::C3; // RULE_18
			// logic ops writing a direct byte
			8'h42, 8'h52, 8'h62: begin dif.len = ilt_pkg::L2; dif.cyc = ilt_pkg::C4; end // RULE_13
			8'h43, 8'h53, 8'h63: begin dif.len = ilt_pkg::L3; dif.cyc = ilt_pkg::C4; end // RULE_13
			// immediate moves
			8'h74, 8'b01111???: begin dif.len = ilt_pkg::L2; dif.cyc = ilt_pkg::C2; end // RULE_01
			8'h75, 8'h90: begin dif.len = ilt_pkg::L3; dif.cyc = ilt_pkg::C3; end // RULE_05
			8'b0111011?, 8'b1010011?: begin dif.len = ilt_pkg::L2; dif.cyc = ilt_pkg::C3; end // RULE_21
			// code lookups, mul, div, decimal adjust
			8'h83, 8'h93, 8'ha4, 8'hd4: dif.cyc = ilt_pkg::C4; // RULE_06
			8'h84: dif.cyc = ilt_pkg::C5;
			// direct destination moves
			8'h85: begin dif.len = ilt_pkg::L3; dif.cyc = ilt_pkg::C4; end // RULE_04
			8'b1000011?, 8'b10101???, 8'h92, 8'hb2, 8'hc0, 8'hc2, 8'hc5, 8'hd2,
			8'b11011???: begin dif.len = ilt_pkg::L2; dif.cyc = ilt_pkg::C4; end // RULE_03
			8'b10001???, 8'hd0, 8'hf5: begin dif.len = ilt_pkg::L2; dif.cyc = ilt_pkg::C3; end // RULE_09
			// compare / decrement and branch
			8'hb4, 8'b10111???: begin dif.len = ilt_pkg::L3; dif.cyc = ilt_pkg::C4; end // RULE_19
			8'hb5, 8'b1011011?, 8'hd5: begin dif.len = ilt_pkg::L3; dif.cyc = ilt_pkg::C5; end // RULE_20
			// exchanges
			8'b1100011?, 8'b1101011?: dif.cyc = ilt_pkg::C4; // RULE_10
			8'b11001???: dif.cyc = ilt_pkg::C3; // RULE_10
			// aux ram moves
			8'he0, 8'b1110001?, 8'hf0, 8'b1111001?: begin dif.cyc = ilt_pkg::C3; dif.is_movx = 1'b1; end // RULE_07
			// accumulator loads and stores
			8'he5: begin dif.len = ilt_pkg::L2; dif.cyc = ilt_pkg::C2; end // RULE_02
			8'b1110011?, 8'hf4, 8'b11111???: dif.cyc = ilt_pkg::C2; // RULE_14
			8'b1111011?: dif.cyc = ilt_pkg::C3;
			// arithmetic and logic rows, accumulator target
			8'b0???0100, 8'h94: begin dif.len = ilt_pkg::L2; dif.cyc = ilt_pkg::C2; end // RULE_11
			8'b0???0101, 8'h95: begin dif.len = ilt_pkg::L2; dif.cyc = ilt_pkg::C3; end // RULE_11
			8'b0???011?, 8'b1001011?: dif.cyc = ilt_pkg::C3; // RULE_13
			8'b0???1???, 8'b10011???: dif.cyc = ilt_pkg::C2; // RULE_11
			// single-cycle forms keep the defaults
			default: dif.cyc = ilt_pkg::C1; // RULE_14
		endcase
		// external aux ram stretches the access
		// same term as is_ext, kept local to avoid a loop through it
		if (dif.is_movx && dif.ext_sel && dif.ext_hit) begin
			dif.cyc = ilt_pkg::X_BASE + ilt_pkg::ilt_cyc_t'(dif.stretch)
				+ ilt_pkg::ilt_cyc_t'({dif.setup_hold, 1'b0}); // RULE_08
		end
	end

	// external only when selected and the address maps outside
	assign dif.is_ext = dif.is_movx & dif.ext_sel & dif.ext_hit; // RULE_08
endmodule : ilt_decoder

// ### test/ilt_prog_mem.sv
// ilt_prog_mem: program memory model feeding operand bytes to the core
// assumes: answers code_req in the same cycle, as the core expects
`timescale 1ns/1ps
module ilt_prog_mem (
	input  wire logic       sys_clk,
	input  wire logic       arst_n,
	input  wire logic       code_req,
	output logic [7:0]      code_rdata
);
	// ----------------------------------------------------------------
	// byte source
	// ----------------------------------------------------------------
	logic [7:0] cnt;  // operand bytes served since reset
	logic [7:0] last; // last byte handed out
	// bytes run 40, 41, ... so the bench can predict every operand
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt  <= 8'h00;
			last <= 8'h00;
		end else if (code_req) begin
			cnt  <= cnt + 8'h01;
			last <= 8'h40 + cnt;
		end
	end
	// not asked: inverse of last byte, never a stale copy
	assign code_rdata = code_req ? 8'h40 + cnt : ~last;
endmodule : ilt_prog_mem

// ### test/ilt_tb.sv
// ilt_tb: self-checking bench for the length and cycle sequencer
// assumes: ilt_pkg, the interface, decoder and core compiled before
`timescale 1ns/1ps
module instr_length_cycle_timing_tb_top;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic              sys_clk = 1'b0;
	logic              arst_n = 1'b0;
	logic              op_valid = 1'b0;
	logic [7:0]        op_byte = 8'h00;
	logic              ext_sel = 1'b0;
	logic              ext_hit = 1'b0;
	logic [1:0]        stretch = 2'h0;
	logic [1:0]        sh_ext = 2'h0;
	logic              op_ready, code_req, instr_ext, busy, instr_done;
	logic [7:0]        code_rdata, opcode, opnd1, opnd2;
	ilt_pkg::ilt_len_t len;
	ilt_pkg::ilt_cyc_t cyc;
	int                n_fail = 0;
	int                comparisons = 0;
	int                base = 0; // operand bytes consumed so far
	// opcode, bytes, cycles packed as one word per instruction
	localparam logic [15:0] TBL [65] = '{
		16'he811, 16'he522, 16'ha824, 16'h8534, 16'h9033,
		16'h9314, 16'h8314,
		16'he013, 16'hf213, 16'he213, 16'hf013,
		16'hc024, 16'hd023,
		16'hc813, 16'hc524, 16'hc614, 16'hd614,
		16'h2812, 16'h2422, 16'h3523, 16'h9613,
		16'h0412, 16'h0813, 16'h0524, 16'h1614, 16'ha311,
		16'h5812, 16'h5523, 16'h4224, 16'h6334,
		16'he411, 16'h2311, 16'h3311, 16'h0311, 16'h1311,
		16'hc411, 16'hf412,
		16'hc311, 16'hd311, 16'hb311, 16'h8223, 16'ha223, 16'h9224,
		16'h4023, 16'h5023, 16'h2034, 16'h3034, 16'h1035,
		16'h1126, 16'h1236, 16'h2214, 16'h3214,
		16'h8023, 16'h0123, 16'h7313, 16'h6023, 16'h7023, 16'h0234,
		16'hb535, 16'hb434, 16'hb834, 16'hb635,
		16'hd824, 16'hd535, 16'h7623};
	// ----------------------------------------------------------------
	// design and program memory
	// ----------------------------------------------------------------
	ilt_core ilt_core_i (.sys_clk(sys_clk), .arst_n(arst_n),
		.op_valid(op_valid), .op_byte(op_byte), .op_ready(op_ready),
		.ext_mem_access_sel(ext_sel), .ext_ram_hit(ext_hit),
		.rw_strobe_stretch(stretch), .rw_setup_hold_ext(sh_ext),
		.code_req(code_req), .code_rdata(code_rdata), .opcode(opcode),
		.opnd1(opnd1), .opnd2(opnd2), .instr_len(len),
		.instr_cycles(cyc), .instr_ext(instr_ext), .busy(busy),
		.instr_done(instr_done));
	ilt_prog_mem ilt_prog_mem_i (.sys_clk(sys_clk), .arst_n(arst_n),
		.code_req(code_req), .code_rdata(code_rdata));
	always #5 sys_clk = ~sys_clk;
	// ----------------------------------------------------------------
	// compare and closing tasks
	// ----------------------------------------------------------------
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t byte got %h want %h", $time, got, exp);
		end
	endtask : chk8
	task automatic chk1(input logic got, input logic exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t flag got %b want %b", $time, got, exp);
		end
	endtask : chk1
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : give_verdict
	task automatic hang();
		n_fail++;
		$display("BAD %0t no answer in time", $time);
		give_verdict();
	endtask : hang
	// one instruction: offer, accept, count cycles, probe refusal
	task automatic exec(input logic [7:0] op, input int el, ec,
		input logic ex);
		int c;
		int nreq;
		int k;
		nreq = 0;
		op_valid = 1'b1;
		op_byte = op;
		for (k = 0; k < 20 && op_ready !== 1'b1; k++) begin
			@(posedge sys_clk);
			#1;
		end
		if (k == 20) hang();
		@(posedge sys_clk);
		#1;
		chk8(8'(len), 8'(el));
		chk1(instr_ext, ex);
		chk1(busy, 1'b1);
		for (c = 1; c <= 16; c++) begin
			if (code_req === 1'b1) nreq++;
			if (instr_done === 1'b1) break;
			if (c == 1) op_byte = 8'ha5; // refused while busy
			@(posedge sys_clk);
			#1;
		end
		if (c > 16) hang();
		chk8(8'(c), 8'(ec));
		chk8(8'(cyc), 8'(ec));
		chk8(opcode, op);
		chk8(8'(nreq), 8'(el - 1));
		if (el > 1) chk8(opnd1, 8'(8'h40 + base));
		if (el > 2) chk8(opnd2, 8'(8'h41 + base));
		base += el - 1;
	endtask : exec
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset_vals();
		chk1(op_ready, 1'b1);
		chk1(busy, 1'b0);
		chk1(instr_done, 1'b0);
		chk8(8'(len), 8'h01);
		chk8(8'(cyc), 8'h01);
		chk1(code_req, 1'b0);
		chk1(instr_ext, 1'b0);
		chk8(opcode, 8'h00);
		chk8(opnd1, 8'h00);
		chk8(opnd2, 8'h00);
		$display("test reset values done");
	endtask : t_reset_vals
	task automatic t_table(); // every row, back to back
		for (int i = 0; i < 65; i++)
			exec(TBL[i][15:8], int'(TBL[i][7:4]), int'(TBL[i][3:0]), 1'b0);
		op_valid = 1'b0;
		$display("test table done");
	endtask : t_table
	task automatic t_ext(); // every stretch and setup/hold setting
		for (int s = 0; s < 4; s++)
			for (int h = 0; h < 4; h++) begin
				ext_sel = 1'b1;
				ext_hit = 1'b1;
				stretch = 2'(s);
				sh_ext = 2'(h);
				// cycle through four of the six aux ram move opcodes (e0, e2, f0, f2)
				exec(8'he0 + 8'((h % 2) * 2) + 8'((s % 2) * 16), 1,
					3 + s + 2 * h, 1'b1);
			end
		ext_sel = 1'b0;
		exec(8'hf0, 1, 3, 1'b0);
		ext_sel = 1'b1;
		ext_hit = 1'b0;
		exec(8'he2, 1, 3, 1'b0);
		op_valid = 1'b0;
		$display("test external ram done");
	endtask : t_ext
	task automatic t_mid_reset(); // reset lands inside a call
		op_valid = 1'b1;
		op_byte = 8'h12;
		repeat (3) @(posedge sys_clk);
		#1;
		op_valid = 1'b0;
		arst_n = 1'b0;
		#1;
		t_reset_vals();
		repeat (2) @(posedge sys_clk);
		#1;
		arst_n = 1'b1;
		base = 0;
		exec(8'h02, 3, 4, 1'b0);
		op_valid = 1'b0;
		$display("test mid reset done");
	endtask : t_mid_reset
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (5) @(posedge sys_clk);
		#1;
		t_reset_vals();
		arst_n = 1'b1;
		t_table();
		t_ext();
		t_mid_reset();
		give_verdict();
	end
endmodule : instr_length_cycle_timing_tb_top
